// *** hw/idlk_fuse.sv ***
`timescale 1ns/1ns
`default_nettype none

// One-time store: takes the image on the first burn after reset and holds it until the next reset.
module idlk_fuse (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic burn_in,
  input wire idlk_pkg::idlk_otp_t img_in,
  output idlk_pkg::idlk_otp_t img_out,
  output logic burned_out
);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      img_out <= idlk_pkg::OTP_RST;
      burned_out <= 1'b0;
    end
    else if (burn_in && !burned_out)
    begin
      img_out <= img_in;
      burned_out <= 1'b1;
    end
  end

endmodule : idlk_fuse

`default_nettype wire

// *** hw/idlk_pkg.sv ***
package idlk_pkg;

  // ----------------------------------------------------------------
  // Register offsets and serial framing
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_IDENT = 7'h00;
  localparam logic [6:0] ADDR_PART = 7'h01;
  localparam logic [6:0] ADDR_PIN = 7'h02;
  localparam logic [6:0] ADDR_OTP_BURN = 7'h7F;
  localparam logic [5:0] HDR_LAST = 6'h07;
  localparam logic [5:0] DATA_FIRST = 6'h08;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [5:0] W_IDENT = 6'h20;
  localparam logic [5:0] W_PART = 6'h30;
  localparam logic [5:0] W_PIN = 6'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BOARD_LO_POS = 28;
  localparam int BOARD_HI_POS = 36;
  localparam int MAKER_POS = 16;
  localparam int REV_POS = 32;
  localparam int HOLD_POS = 19;
  localparam int ARM_POS = 18;
  localparam int DRV_POS = 17;
  localparam int SEL_POS = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BOARD_TAG_RST = 8'h00;
  localparam logic [31:0] USER_TAG_RST = 32'h0000_0000;
  localparam logic [15:0] LOCK_MASK_RST = 16'h0000;

  typedef struct packed {
    logic [7:0] board_tag;
    logic [31:0] user_tag;
    logic [15:0] lock_mask;
  } idlk_otp_t;

  localparam idlk_otp_t OTP_RST = '{BOARD_TAG_RST, USER_TAG_RST,
                                    LOCK_MASK_RST};

endpackage : idlk_pkg

// *** hw/idlk_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

module idlk_regs #(
  parameter logic [10:0] MAKER_CODE = 11'h2A5,  // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'h5C,  // Arbitrary value.
  parameter logic [3:0] SILICON_REV = 4'h1  // Arbitrary value.
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic spi_sclk_in,
  input wire logic spi_csn_in,
  input wire logic spi_sdi_in,
  input wire logic reference_copy_pin_enable_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  output logic chip_hold_reset_out,
  output logic reference_copy_driver_on_out
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_s1_reg, rst_n;
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic csn_s1_reg, csn_s2_reg, sdi_s1_reg, sdi_s2_reg;
  logic pin_s1_reg, pin_s2_reg;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h0;
      {csn_s1_reg, csn_s2_reg} <= 2'h3;
      {sdi_s1_reg, sdi_s2_reg, pin_s1_reg, pin_s2_reg} <= 4'h0;
    end
    else
    begin
      sclk_s1_reg <= spi_sclk_in;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      csn_s1_reg <= spi_csn_in;
      csn_s2_reg <= csn_s1_reg;
      sdi_s1_reg <= spi_sdi_in;
      sdi_s2_reg <= sdi_s1_reg;
      pin_s1_reg <= reference_copy_pin_enable_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0] cnt_reg;
  logic [7:0] hdr_reg;
  logic [47:0] wsh_reg, rsh_reg;
  logic [7:0] board_tag_reg;
  logic [31:0] user_tag_reg;
  logic [15:0] lock_mask_reg;
  logic hold_reg, arm_reg, drv_reg, sel_reg;
  idlk_pkg::idlk_otp_t fuse_img;
  logic burned;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg & ~csn_s2_reg;
  wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg & ~csn_s2_reg;
  wire hdr_end = sclk_rise && (cnt_reg == idlk_pkg::HDR_LAST);
  wire [7:0] hdr_now = {hdr_reg[6:0], sdi_s2_reg};
  wire [47:0] wnow = {wsh_reg[46:0], sdi_s2_reg};
  wire is_read = hdr_reg[7];
  wire [6:0] addr = hdr_reg[6:0];
  wire [6:0] addr_now = hdr_now[6:0];
  wire [5:0] width = (addr == idlk_pkg::ADDR_IDENT) ? idlk_pkg::W_IDENT :
                     (addr == idlk_pkg::ADDR_PART) ? idlk_pkg::W_PART :
                     (addr == idlk_pkg::ADDR_PIN) ? idlk_pkg::W_PIN : 6'h00;
  wire [15:0] eff_lock = burned ? fuse_img.lock_mask : 16'h0000;
  // Locking only takes hold once the fuses are burned.
  wire locked = (addr[6:4] == 3'h0) && eff_lock[addr[3:0]];
  wire wr_end = sclk_rise && !is_read && (width != 6'h00) &&
                (cnt_reg == width + idlk_pkg::HDR_LAST);
  wire commit = wr_end && !locked;
  wire burn = hdr_end && !hdr_now[7] &&
              (addr_now == idlk_pkg::ADDR_OTP_BURN);
  wire [7:0] board_rd = burned ? fuse_img.board_tag : board_tag_reg;
  wire [31:0] user_rd = burned ? fuse_img.user_tag : user_tag_reg;
  wire drv_rd = sel_reg ? drv_reg : pin_s2_reg;
  // Bit 27 and bits 23:20 are unused and read zero.
  wire [31:0] rd0 = {board_rd[3:0], 1'b0, MAKER_CODE,
                     lock_mask_reg};
  wire [47:0] rd1 = {PART_CODE, board_rd[7:4], SILICON_REV,
                     user_rd};
  wire [23:0] rd2 = {4'h0, hold_reg, arm_reg, drv_rd, sel_reg,
                     16'h0000};
  wire [47:0] rd_load = (addr_now == idlk_pkg::ADDR_IDENT) ? {rd0, 16'h0000} :
                        (addr_now == idlk_pkg::ADDR_PART) ? rd1 :
                        (addr_now == idlk_pkg::ADDR_PIN) ? {rd2, 24'h000000} :
                        48'h0000_0000_0000;
  wire [5:0] cnt_next = (cnt_reg == idlk_pkg::CNT_MAX) ? cnt_reg :
                        cnt_reg + 6'h01;
  wire data_phase = cnt_reg >= idlk_pkg::DATA_FIRST;
  wire wr_ident = commit && (addr == idlk_pkg::ADDR_IDENT);
  wire wr_part = commit && (addr == idlk_pkg::ADDR_PART);
  wire wr_pin = commit && (addr == idlk_pkg::ADDR_PIN);
  wire idlk_pkg::idlk_otp_t shadow = '{board_tag_reg, user_tag_reg,
                                       lock_mask_reg};

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 6'h00;
      hdr_reg <= 8'h00;
      wsh_reg <= 48'h0000_0000_0000;
      rsh_reg <= 48'h0000_0000_0000;
      spi_sdo_out <= 1'b0;
      spi_sdo_oe_out <= 1'b0;
    end
    else
    begin
      if (csn_s2_reg)
        cnt_reg <= 6'h00;
      else if (sclk_rise)
        cnt_reg <= cnt_next;
      if (sclk_rise && !data_phase)
        hdr_reg <= hdr_now;
      if (sclk_rise && data_phase)
        wsh_reg <= wnow;
      if (hdr_end)
        rsh_reg <= rd_load;
      else if (sclk_fall && data_phase)
        rsh_reg <= {rsh_reg[46:0], 1'b0};
      if (sclk_fall && data_phase)
        spi_sdo_out <= rsh_reg[47];
      spi_sdo_oe_out <= ~csn_s2_reg & is_read & data_phase;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // Maker code and revision are constants, so writes cannot touch them.
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      board_tag_reg <= idlk_pkg::BOARD_TAG_RST;
      user_tag_reg <= idlk_pkg::USER_TAG_RST;
      lock_mask_reg <= idlk_pkg::LOCK_MASK_RST;
      {hold_reg, arm_reg, drv_reg, sel_reg} <= 4'h0;
    end
    else
    begin
      if (wr_ident)
      begin
        board_tag_reg[3:0] <= wnow[idlk_pkg::BOARD_LO_POS +: 4];
        lock_mask_reg <= wnow[15:0];
      end
      if (wr_part)
      begin
        board_tag_reg[7:4] <= wnow[idlk_pkg::BOARD_HI_POS +: 4];
        user_tag_reg <= wnow[31:0];
      end
      if (wr_pin)
      begin
        hold_reg <= wnow[idlk_pkg::HOLD_POS];
        arm_reg <= wnow[idlk_pkg::ARM_POS];
        sel_reg <= wnow[idlk_pkg::SEL_POS];
        if (wnow[idlk_pkg::SEL_POS])
          drv_reg <= wnow[idlk_pkg::DRV_POS];
      end
    end
  end

  idlk_fuse u_fuse (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .burn_in(burn),
    .img_in(shadow),
    .img_out(fuse_img),
    .burned_out(burned)
  );

  // ----------------------------------------------------------------
  // Chip outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_hold_reset_out <= 1'b0;
      reference_copy_driver_on_out <= 1'b0;
    end
    else
    begin
      chip_hold_reset_out <= hold_reg & arm_reg;
      reference_copy_driver_on_out <= drv_rd;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n);

  a_hold_needs_arm: assert property (
    chip_hold_reset_out |-> $past(arm_reg))
    else $error("Hold reset without arm bit.");
  a_hold_not_self_clear: assert property (
    hold_reg && arm_reg && !wr_pin |=> hold_reg ##1 chip_hold_reset_out)
    else $error("Hold reset cleared itself.");
  a_drv_from_reg: assert property (
    sel_reg && $past(sel_reg) |-> ##1 reference_copy_driver_on_out ==
      $past(drv_reg))
    else $error("Driver not following register bit.");
  a_drv_from_pin: assert property (
    !sel_reg |=> reference_copy_driver_on_out == $past(pin_s2_reg))
    else $error("Driver not following enable pin.");
  a_pin_readback: assert property (
    !sel_reg |-> rd2[idlk_pkg::DRV_POS] == pin_s2_reg)
    else $error("Readback does not show the pin.");
  a_lock_blocks_write: assert property (
    wr_end && locked |=> $stable(board_tag_reg) && $stable(user_tag_reg) &&
      $stable(lock_mask_reg) && $stable({hold_reg, arm_reg, sel_reg}))
    else $error("Locked register changed.");
  a_maker_fixed: assert property (
    rd0[26:16] == MAKER_CODE)
    else $error("Maker code changed.");
  a_rev_fixed: assert property (
    rd1[35:32] == SILICON_REV)
    else $error("Revision changed.");
  a_unused_zero: assert property (
    rd0[27] == 1'b0 && rd2[23:20] == 4'h0)
    else $error("Unused bits not zero.");
  a_otp_once: assert property (
    burned |=> $stable(fuse_img) && burned)
    else $error("Fuse image changed after burn.");
  a_tag_from_fuse: assert property (
    burned |-> rd0[31:28] == fuse_img.board_tag[3:0] &&
      rd1[31:0] == fuse_img.user_tag)
    else $error("Tags not taken from fuses.");
  a_mask_reads: assert property (
    wr_ident |=> rd0[15:0] == $past(wnow[15:0]))
    else $error("Lock mask not written.");

  c_burn: cover property (burn && !burned);
  c_hold: cover property (chip_hold_reset_out);
  c_locked_write: cover property (wr_end && locked);
  c_read_frame: cover property (spi_sdo_oe_out);

endmodule : idlk_regs

`default_nettype wire

// *** verif/idlk_host.sv ***
`timescale 1ns/1ns
`default_nettype none

// Serial host: one frame per call, every pin moved on the falling clock.
module idlk_host (
  input wire logic ref_clk_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic sclk_out,
  output logic csn_out,
  output logic sdi_out,
  output logic rd_valid_out,
  output logic [47:0] rd_data_out
);
  initial
  begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    sdi_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = '0;
  end

  // Half periods of six clocks keep each level above the sync minimum.
  // A bit sampled while the device is not driving reads as unknown.
  task automatic frame(input logic rd, input logic [6:0] addr,
                       input logic [47:0] wd, input int nbits);
    logic [55:0] sh;
    logic [47:0] got;
    sh = {rd, addr, wd << (48 - nbits)};
    got = '0;
    @(negedge ref_clk_in);
    csn_out = 1'b0;
    for (int i = 0; i < 8 + nbits; i++)
    begin
      sdi_out = (rd && i >= 8) ? ~sdi_out : sh[55 - i];
      repeat (6) @(negedge ref_clk_in);
      sclk_out = 1'b1;
      if (rd && i >= 8)
        got = {got[46:0], sdo_oe_in ? sdo_in : 1'bx};
      repeat (6) @(negedge ref_clk_in);
      sclk_out = 1'b0;
    end
    repeat (6) @(negedge ref_clk_in);
    csn_out = 1'b1;
    rd_data_out = got;
    rd_valid_out = rd;
    @(negedge ref_clk_in);
    rd_valid_out = 1'b0;
    repeat (8) @(negedge ref_clk_in);
  endtask : frame
endmodule : idlk_host

`default_nettype wire

// *** verif/test_id_lock_pin_override_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_id_lock_pin_override_regs;
  localparam logic [10:0] MK = 11'h4B3;  // Arbitrary value.
  localparam logic [7:0] PC = 8'hA7;  // Arbitrary value.
  localparam logic [3:0] RV = 4'h6;  // Arbitrary value.
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic pin = 1'b0;
  logic smp = 1'b0;
  logic dreg = 1'b0;
  logic [1:0] m;
  logic [47:0] w;
  logic [47:0] q[$];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  wire logic sclk, csn, sdi, sdo, sdo_oe, hold, drv, rd_valid;
  wire logic [47:0] rd_data;

  idlk_regs #(.MAKER_CODE(MK), .PART_CODE(PC), .SILICON_REV(RV)) dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .spi_sclk_in(sclk),
    .spi_csn_in(csn), .spi_sdi_in(sdi),
    .reference_copy_pin_enable_in(pin), .spi_sdo_out(sdo),
    .spi_sdo_oe_out(sdo_oe), .chip_hold_reset_out(hold),
    .reference_copy_driver_on_out(drv));
  idlk_host host (.ref_clk_in(ref_clk_in), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe), .sclk_out(sclk), .csn_out(csn), .sdi_out(sdi),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data));

  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk_in)
  begin
    if (rd_valid)
      check(rd_data, q.pop_front());
    if (smp)
      check({46'h0, hold, drv}, q.pop_front());
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  function automatic logic [47:0] r0(input logic [7:0] bt,
                                     input logic [15:0] lk);
    return {16'h0, bt[3:0], 1'b0, MK, lk};
  endfunction : r0

  function automatic logic [47:0] r1(input logic [7:0] bt,
                                     input logic [31:0] ut);
    return {PC, bt[7:4], RV, ut};
  endfunction : r1

  function automatic logic [47:0] r2(input logic h, input logic a,
                                     input logic d, input logic s);
    return {28'h0, h, a, d, s, 16'h0};
  endfunction : r2

  task automatic rd(input logic [6:0] a, input int n, input logic [47:0] e);
    q.push_back(e);
    host.frame(1'b1, a, '0, n);
  endtask : rd

  task automatic wr(input logic [6:0] a, input int n, input logic [47:0] d);
    host.frame(1'b0, a, d, n);
  endtask : wr

  // The pin passes two syncs and a register to drv, and hold only a register, so eight clocks is ample.
  task automatic outs(input logic h, input logic d);
    q.push_back({46'h0, h, d});
    repeat (8) @(negedge ref_clk_in);
    smp = 1'b1;
    @(negedge ref_clk_in);
    smp = 1'b0;
  endtask : outs

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(43575));
    repeat (2) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    pin = 1'b1;
    rd(idlk_pkg::ADDR_IDENT, 32, r0(8'h00, 16'h0000));
    rd(idlk_pkg::ADDR_PART, 48, r1(8'h00, 32'h0));
    rd(idlk_pkg::ADDR_PIN, 24, r2(1'b0, 1'b0, 1'b1, 1'b0));
    rd(7'h05, 24, 48'h0);
    outs(1'b0, 1'b1);
    $display("reset values done");
    w = {16'($urandom), 32'($urandom)};
    wr(idlk_pkg::ADDR_IDENT, 32, w);
    rd(idlk_pkg::ADDR_IDENT, 32, r0({4'h0, w[31:28]}, w[15:0]));
    wr(idlk_pkg::ADDR_PART, 48, w);
    rd(idlk_pkg::ADDR_PART, 48, r1({w[39:36], w[31:28]}, w[31:0]));
    $display("field writes done");
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      pin = 1'($urandom);
      wr(idlk_pkg::ADDR_PIN, 24, r2(1'b0, 1'b0, m[1], m[0]));
      if (m[0])
        dreg = m[1];
      rd(idlk_pkg::ADDR_PIN, 24,
         r2(1'b0, 1'b0, m[0] ? dreg : pin, m[0]));
      outs(1'b0, m[0] ? dreg : pin);
    end
    $display("override done");
    wr(idlk_pkg::ADDR_PIN, 24, r2(1'b1, 1'b0, 1'b0, 1'b0));
    outs(1'b0, pin);
    wr(idlk_pkg::ADDR_PIN, 24, r2(1'b1, 1'b1, 1'b0, 1'b0));
    outs(1'b1, pin);
    repeat (200) @(negedge ref_clk_in);
    outs(1'b1, pin);
    rd(idlk_pkg::ADDR_PIN, 24, r2(1'b1, 1'b1, pin, 1'b0));
    wr(idlk_pkg::ADDR_PIN, 24, r2(1'b0, 1'b0, 1'b0, 1'b0));
    outs(1'b0, pin);
    $display("hold reset done");
    wr(idlk_pkg::ADDR_IDENT, 32, {16'h0, 4'h9, 12'h0, 16'h0002});
    wr(idlk_pkg::ADDR_PART, 48, {8'h00, 4'h3, 4'h0, 32'hC0DE_1234});
    wr(idlk_pkg::ADDR_OTP_BURN, 0, '0);
    wr(idlk_pkg::ADDR_PART, 48, ~w);
    rd(idlk_pkg::ADDR_PART, 48, r1(8'h39, 32'hC0DE_1234));
    wr(idlk_pkg::ADDR_IDENT, 32, {16'h0, 4'h5, 12'h0, 16'h0002});
    wr(idlk_pkg::ADDR_OTP_BURN, 0, '0);
    rd(idlk_pkg::ADDR_IDENT, 32, r0(8'h39, 16'h0002));
    $display("lock done");
    end_of_test();
  end
endmodule : test_id_lock_pin_override_regs

`default_nettype wire
